// [design/uifc_control.sv]
// Interrupt enable, identification, wake-up, divisor high byte and queue control of the UART.
// Assumes SFR bus strobes are one-cycle pulses, and that the shifters, line and modem status sit outside.
// Function
// - Four enable bits: rx data, tx empty, line status, modem status.
// - Wake enable lets falling edge on serial in or ring raise wake interrupt while power_manage_state is set.
// - Wake flag reads one after this UART woke, clears when read.
// - Divisor high byte shares the enable address, holds divisor bits 15:8.
// - Line status code has top priority, cleared by reading line status.
// - Rx available code holds until fill level drops below threshold.
// - Rx timeout code 1100 is cleared by reading the receive buffer.
// - Tx empty code cleared by holding write or identification read.
// - Modem code lowest, cleared by reading modem status.
// - Identification read-only, idle 0001, bits 5:4 zero, 7:6 one.
// - Rx flush bit empties receive queue and self-clears.
// - Tx flush bit empties transmit queue and self-clears.
// - Threshold field selects 1, 4, 8 or 14 bytes.
// - Divisor access bit steers shared addresses to divisor bytes.
// - Baud equals clock over 27 times the divisor.
`timescale 1ns/10ps
module uifc_control (
   input wire logic mclk,
   input wire logic reset,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   output logic [7:0] sfr_rdata,
   input wire logic divisor_access,
   input wire logic line_err_event,
   input wire logic rx_timeout_event,
   input wire logic tx_empty_event,
   input wire logic modem_event,
   input wire logic [4:0] rx_fill_level,
   input wire logic serial_in_pin,
   input wire logic ring_pin,
   input wire logic power_manage_state,
   output logic uart_irq,
   output logic wake_irq,
   output logic rx_queue_flush,
   output logic tx_queue_flush,
   output logic [1:0] rx_threshold_sel,
   output logic [15:0] baud_divisor,
   output logic [5:0] baud_prescale
);
   ////////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [4:0] irq_en;
      logic wake_flag;
      logic [7:0] baud_div_high;
      logic [7:0] baud_div_low;
      logic [1:0] thresh;
      logic rx_flush;
      logic tx_flush;
      logic line_err_pend;
      logic rx_timeout_pend;
      logic tx_empty_pend;
      logic modem_pend;
      logic serial_prev;
      logic ring_prev;
      logic wake_irq;
      logic [7:0] rdata;
   } uifc_state_type;

   uifc_state_type cur, nxt;
   logic wr_en, wr_id, rd_en, rd_id, rd_line, rd_modem, rd_rxbuf, wr_hold;
   logic rx_avail, fall_seen;
   logic [4:0] thresh_bytes;
   logic [3:0] id_code;

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      wr_en = sfr_wr && sfr_addr == uifc_pkg::ADDR_IRQ_EN;
      wr_id = sfr_wr && sfr_addr == uifc_pkg::ADDR_IRQ_ID;
      rd_en = sfr_rd && sfr_addr == uifc_pkg::ADDR_IRQ_EN;
      rd_id = sfr_rd && sfr_addr == uifc_pkg::ADDR_IRQ_ID;
      // Line and modem status registers live outside; only their reads matter here
      rd_line = sfr_rd && sfr_addr == uifc_pkg::ADDR_LINE_STAT;
      rd_modem = sfr_rd && sfr_addr == uifc_pkg::ADDR_MODEM_STAT;
      rd_rxbuf = sfr_rd && sfr_addr == uifc_pkg::ADDR_DIV_LOW && !divisor_access;
      wr_hold = sfr_wr && sfr_addr == uifc_pkg::ADDR_DIV_LOW && !divisor_access;
      case (cur.thresh)
         2'h0: thresh_bytes = uifc_pkg::THRESH_1;
         2'h1: thresh_bytes = uifc_pkg::THRESH_4;
         2'h2: thresh_bytes = uifc_pkg::THRESH_8;
         default: thresh_bytes = uifc_pkg::THRESH_14;
      endcase
      rx_avail = rx_fill_level >= thresh_bytes;
      // Priority encoder over enabled sources only
      if (cur.line_err_pend && cur.irq_en[uifc_pkg::LINE_ERR_EN_BIT]) begin
         id_code = uifc_pkg::ID_LINE_ERR;
      end else if (rx_avail && cur.irq_en[uifc_pkg::RX_AVAIL_EN_BIT]) begin
         id_code = uifc_pkg::ID_RX_AVAIL;
      end else if (cur.rx_timeout_pend && cur.irq_en[uifc_pkg::RX_AVAIL_EN_BIT]) begin
         id_code = uifc_pkg::ID_RX_TIMEOUT;
      end else if (cur.tx_empty_pend && cur.irq_en[uifc_pkg::TX_EMPTY_EN_BIT]) begin
         id_code = uifc_pkg::ID_TX_EMPTY;
      end else if (cur.modem_pend && cur.irq_en[uifc_pkg::MODEM_EN_BIT]) begin
         id_code = uifc_pkg::ID_MODEM;
      end else begin
         id_code = uifc_pkg::ID_NONE;
      end
      fall_seen = (cur.serial_prev && !serial_in_pin) || (cur.ring_prev && !ring_pin);

      nxt = cur;
      nxt.serial_prev = serial_in_pin;
      nxt.ring_prev = ring_pin;
      nxt.rx_flush = 1'b0;
      nxt.tx_flush = 1'b0;
      if (wr_en) begin
         if (divisor_access) begin
            nxt.baud_div_high = sfr_wdata;
         end else begin
            nxt.irq_en = sfr_wdata[4:0];
         end
      end
      if (sfr_wr && sfr_addr == uifc_pkg::ADDR_DIV_LOW && divisor_access) begin
         nxt.baud_div_low = sfr_wdata;
      end
      if (wr_id) begin
         nxt.thresh = sfr_wdata[uifc_pkg::THRESH_HI:uifc_pkg::THRESH_LO];
         nxt.rx_flush = sfr_wdata[uifc_pkg::RX_FLUSH_BIT];
         nxt.tx_flush = sfr_wdata[uifc_pkg::TX_FLUSH_BIT];
      end
      // Clears first, events after, so a coincident event survives
      if (rd_line) nxt.line_err_pend = 1'b0;
      if (rd_rxbuf || (wr_id && sfr_wdata[uifc_pkg::RX_FLUSH_BIT])) nxt.rx_timeout_pend = 1'b0;
      if (wr_hold || (rd_id && id_code == uifc_pkg::ID_TX_EMPTY)) begin
         nxt.tx_empty_pend = 1'b0;
      end
      if (rd_modem) nxt.modem_pend = 1'b0;
      if (line_err_event) nxt.line_err_pend = 1'b1;
      if (rx_timeout_event) nxt.rx_timeout_pend = 1'b1;
      if (tx_empty_event) nxt.tx_empty_pend = 1'b1;
      if (modem_event) nxt.modem_pend = 1'b1;
      // Wake only while asleep, so normal line traffic raises nothing
      nxt.wake_irq = cur.irq_en[uifc_pkg::WAKE_EN_BIT] && power_manage_state && fall_seen;
      if (rd_en && !divisor_access) nxt.wake_flag = 1'b0;
      if (cur.wake_irq) nxt.wake_flag = 1'b1;
      nxt.rdata = 8'h00;
      if (rd_en) begin
         nxt.rdata = divisor_access ? cur.baud_div_high : {2'h0, cur.wake_flag, cur.irq_en};
      end else if (rd_id) begin
         nxt.rdata = {uifc_pkg::ID_TOP_BITS, 2'h0, id_code};
      end else if (sfr_rd && sfr_addr == uifc_pkg::ADDR_DIV_LOW && divisor_access) begin
         nxt.rdata = cur.baud_div_low;
      end
      if (reset) begin
         nxt = '0;
         nxt.irq_en = uifc_pkg::IRQ_EN_RESET[4:0];
         nxt.baud_div_high = uifc_pkg::DIV_HIGH_RESET;
         nxt.thresh = uifc_pkg::QCTRL_RESET[uifc_pkg::THRESH_HI:uifc_pkg::THRESH_LO];
         nxt.serial_prev = 1'b1;
         nxt.ring_prev = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      cur <= nxt;
   end

   ////////////////////////////////////////////////////////////////////////////////
   assign sfr_rdata = cur.rdata;
   assign uart_irq = id_code != uifc_pkg::ID_NONE;
   assign wake_irq = cur.wake_irq;
   assign rx_queue_flush = cur.rx_flush;
   assign tx_queue_flush = cur.tx_flush;
   assign rx_threshold_sel = cur.thresh;
   // Divisor goes straight out, both bytes taken from their registers
   assign baud_divisor = {cur.baud_div_high, cur.baud_div_low};
   assign baud_prescale = 6'(uifc_pkg::BAUD_PRESCALE);

   ////////////////////////////////////////////////////////////////////////////////
   // Wake path
   wake_edge_a: assert property (@(posedge mclk) disable iff (reset)
      (cur.irq_en[uifc_pkg::WAKE_EN_BIT] && power_manage_state && $fell(serial_in_pin))
      |=> wake_irq)
      else $error("wake edge missed");

   ring_wake_a: assert property (@(posedge mclk) disable iff (reset)
      (cur.irq_en[uifc_pkg::WAKE_EN_BIT] && power_manage_state && $fell(ring_pin))
      |=> wake_irq)
      else $error("ring wake missed");

   wake_awake_a: assert property (@(posedge mclk) disable iff (reset)
      !power_manage_state
      |=> !wake_irq)
      else $error("wake while running");

   wake_off_a: assert property (@(posedge mclk) disable iff (reset)
      !cur.irq_en[uifc_pkg::WAKE_EN_BIT]
      |=> !wake_irq)
      else $error("wake while disabled");

   wake_flag_a: assert property (@(posedge mclk) disable iff (reset)
      wake_irq
      |=> cur.wake_flag)
      else $error("wake flag not set");

   wake_clear_a: assert property (@(posedge mclk) disable iff (reset)
      (rd_en && !divisor_access && !wake_irq)
      |=> !cur.wake_flag)
      else $error("wake flag not cleared");

   ////////////////////////////////////////////////////////////////////////////////
   // Enable and divisor registers
   irq_en_wr_a: assert property (@(posedge mclk) disable iff (reset)
      (wr_en && !divisor_access)
      |=> cur.irq_en == $past(sfr_wdata[4:0]))
      else $error("enable write lost");

   en_read_a: assert property (@(posedge mclk) disable iff (reset)
      (rd_en && !divisor_access)
      |=> sfr_rdata[7:6] == 2'h0 && sfr_rdata[4:0] == $past(cur.irq_en))
      else $error("enable read wrong");

   div_high_a: assert property (@(posedge mclk) disable iff (reset)
      (wr_en && divisor_access)
      |=> baud_divisor[15:8] == $past(sfr_wdata))
      else $error("divisor high wrong");

   div_low_a: assert property (@(posedge mclk) disable iff (reset)
      (sfr_wr && sfr_addr == uifc_pkg::ADDR_DIV_LOW && divisor_access)
      |=> baud_divisor[7:0] == $past(sfr_wdata))
      else $error("divisor low wrong");

   div_read_a: assert property (@(posedge mclk) disable iff (reset)
      (rd_en && divisor_access)
      |=> sfr_rdata == $past(cur.baud_div_high))
      else $error("divisor read wrong");

   en_keep_a: assert property (@(posedge mclk) disable iff (reset)
      (wr_en && divisor_access)
      |=> cur.irq_en == $past(cur.irq_en))
      else $error("enable hit by divisor write");

   rdata_idle_a: assert property (@(posedge mclk) disable iff (reset)
      !sfr_rd
      |=> sfr_rdata == 8'h00)
      else $error("read data not idle");

   ////////////////////////////////////////////////////////////////////////////////
   // Identification and pending sources
   id_fixed_a: assert property (@(posedge mclk) disable iff (reset)
      $past(rd_id)
      |-> sfr_rdata[7:4] == 4'hc)
      else $error("id fixed bits wrong");

   id_idle_a: assert property (@(posedge mclk) disable iff (reset)
      (!cur.line_err_pend && !cur.rx_timeout_pend && !cur.tx_empty_pend && !cur.modem_pend && !rx_avail)
      |-> !uart_irq && id_code == uifc_pkg::ID_NONE)
      else $error("id not idle");

   line_top_a: assert property (@(posedge mclk) disable iff (reset)
      (cur.line_err_pend && cur.irq_en[uifc_pkg::LINE_ERR_EN_BIT])
      |-> uart_irq && id_code == uifc_pkg::ID_LINE_ERR)
      else $error("line status not top");

   line_clear_a: assert property (@(posedge mclk) disable iff (reset)
      (rd_line && !line_err_event)
      |=> !cur.line_err_pend)
      else $error("line status not cleared");

   rx_avail_a: assert property (@(posedge mclk) disable iff (reset)
      (cur.irq_en[0] && !(cur.line_err_pend && cur.irq_en[2]) && rx_fill_level >= thresh_bytes)
      |-> id_code == uifc_pkg::ID_RX_AVAIL)
      else $error("rx available not reported");

   rx_low_a: assert property (@(posedge mclk) disable iff (reset)
      (rx_fill_level < thresh_bytes)
      |-> id_code != uifc_pkg::ID_RX_AVAIL)
      else $error("rx available below threshold");

   rxbuf_clear_a: assert property (@(posedge mclk) disable iff (reset)
      (rd_rxbuf && !rx_timeout_event)
      |=> !cur.rx_timeout_pend)
      else $error("rx timeout not cleared");

   hold_clear_a: assert property (@(posedge mclk) disable iff (reset)
      (wr_hold && !tx_empty_event)
      |=> !cur.tx_empty_pend)
      else $error("tx empty not cleared by write");

   id_read_clear_a: assert property (@(posedge mclk) disable iff (reset)
      (rd_id && id_code == uifc_pkg::ID_TX_EMPTY && !tx_empty_event)
      |=> !cur.tx_empty_pend)
      else $error("tx empty not cleared by read");

   modem_clear_a: assert property (@(posedge mclk) disable iff (reset)
      (rd_modem && !modem_event)
      |=> !cur.modem_pend)
      else $error("modem status not cleared");

   hidden_a: assert property (@(posedge mclk) disable iff (reset)
      (cur.irq_en[3:0] == 4'h0)
      |-> !uart_irq)
      else $error("disabled source reported");

   ////////////////////////////////////////////////////////////////////////////////
   // Queue control
   flush_pulse_a: assert property (@(posedge mclk) disable iff (reset)
      rx_queue_flush
      |=> !rx_queue_flush)
      else $error("rx flush stuck");

   rx_flush_set_a: assert property (@(posedge mclk) disable iff (reset)
      (wr_id && sfr_wdata[uifc_pkg::RX_FLUSH_BIT])
      |=> rx_queue_flush)
      else $error("rx flush missed");

   txflush_a: assert property (@(posedge mclk) disable iff (reset)
      (wr_id && sfr_wdata[uifc_pkg::TX_FLUSH_BIT])
      |=> tx_queue_flush ##1 !tx_queue_flush)
      else $error("tx flush wrong");

   thresh_a: assert property (@(posedge mclk) disable iff (reset)
      wr_id
      |=> rx_threshold_sel == $past(sfr_wdata[uifc_pkg::THRESH_HI:uifc_pkg::THRESH_LO]))
      else $error("threshold not taken");
endmodule

// [design/uifc_pkg.sv]
// Constants shared by the UART interrupt, wake and queue control block.
// Assumes an 8-bit special function register bus from the processor core.
package uifc_pkg;
   localparam logic [7:0] ADDR_IRQ_EN = 8'he2;
   localparam logic [7:0] ADDR_IRQ_ID = 8'he3;
   localparam logic [7:0] ADDR_DIV_LOW = 8'he1;
   localparam logic [7:0] ADDR_LINE_STAT = 8'he6;
   localparam logic [7:0] ADDR_MODEM_STAT = 8'he7;
   localparam int RX_AVAIL_EN_BIT = 0;
   localparam int TX_EMPTY_EN_BIT = 1;
   localparam int LINE_ERR_EN_BIT = 2;
   localparam int MODEM_EN_BIT = 3;
   localparam int WAKE_EN_BIT = 4;
   localparam int WAKE_FLAG_BIT = 5;
   localparam int QMODE_BIT = 0;
   localparam int RX_FLUSH_BIT = 1;
   localparam int TX_FLUSH_BIT = 2;
   localparam int THRESH_HI = 7;
   localparam int THRESH_LO = 6;
   localparam logic [7:0] IRQ_EN_RESET = 8'h00;
   localparam logic [7:0] DIV_HIGH_RESET = 8'h00;
   localparam logic [7:0] QCTRL_RESET = 8'hc1;
   localparam logic [1:0] ID_TOP_BITS = 2'h3;
   localparam logic [3:0] ID_NONE = 4'h1;
   localparam logic [3:0] ID_LINE_ERR = 4'h6;
   localparam logic [3:0] ID_RX_AVAIL = 4'h4;
   localparam logic [3:0] ID_RX_TIMEOUT = 4'hc;
   localparam logic [3:0] ID_TX_EMPTY = 4'h2;
   localparam logic [3:0] ID_MODEM = 4'h0;
   localparam logic [4:0] THRESH_1 = 5'h01;
   localparam logic [4:0] THRESH_4 = 5'h04;
   localparam logic [4:0] THRESH_8 = 5'h08;
   localparam logic [4:0] THRESH_14 = 5'h0e;
   localparam int BAUD_PRESCALE = 27;
endpackage

// [verification/uifc_line_peer.sv]
// Far-side serial peer: drives the receive data and ring pins.
// Assumes the bench asks for a falling edge by raising a request bit.
`timescale 1ns/10ps
module uifc_line_peer (
   input wire logic mclk,
   input wire logic [1:0] fall_req,
   output logic serial_in_pin,
   output logic ring_pin
);
   // Both lines idle high, as a marking serial line and an inactive ring
   initial begin
      serial_in_pin = 1'b1;
      ring_pin = 1'b1;
   end
   always @(posedge mclk) begin
      serial_in_pin <= #1 ~fall_req[0];
      ring_pin <= #1 ~fall_req[1];
   end
endmodule

// [verification/tb_uifc_control.sv]
// Self-checking bench for the UART interrupt, wake and queue control block.
// Assumes one clock and a line peer model on the pin side.
`timescale 1ns/10ps
module tb_uifc_control;
   logic mclk = 0, reset = 1, sfr_wr = 0, sfr_rd = 0, divisor_access = 0, power_manage_state = 0;
   logic line_err_event = 0, rx_timeout_event = 0, tx_empty_event = 0, modem_event = 0;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, rd;
   logic [4:0] rx_fill_level = 5'h00;
   logic [1:0] rx_threshold_sel, fall_req = 2'h0;
   logic serial_in_pin, ring_pin, uart_irq, wake_irq, rx_queue_flush, tx_queue_flush;
   logic [15:0] baud_divisor;
   logic [5:0] baud_prescale;
   logic [31:0] seed = 32'd57759, r;
   logic [3:0] e;
   int mismatches = 0, checked = 0, cyc = 0, n;
   uifc_control i_uifc_control (.mclk(mclk), .reset(reset), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
      .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .divisor_access(divisor_access),
      .line_err_event(line_err_event), .rx_timeout_event(rx_timeout_event), .tx_empty_event(tx_empty_event),
      .modem_event(modem_event), .rx_fill_level(rx_fill_level), .serial_in_pin(serial_in_pin),
      .ring_pin(ring_pin), .power_manage_state(power_manage_state), .uart_irq(uart_irq),
      .wake_irq(wake_irq), .rx_queue_flush(rx_queue_flush), .tx_queue_flush(tx_queue_flush),
      .rx_threshold_sel(rx_threshold_sel), .baud_divisor(baud_divisor), .baud_prescale(baud_prescale));
   uifc_line_peer i_uifc_line_peer (.mclk(mclk), .fall_req(fall_req), .serial_in_pin(serial_in_pin),
      .ring_pin(ring_pin));
   ////////////////////////////////////////////////////////////////////////////////
   always #2 mclk = ~mclk;
   // Generous ceiling: the whole sequence needs well under a thousand cycles
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 5000) begin
         mismatches++;
         give_verdict;
      end
   end
   function logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function logic [4:0] thr(input int s);
      return (s == 0) ? 5'h01 : (s == 1) ? 5'h04 : (s == 2) ? 5'h08 : 5'h0e;
   endfunction
   // Event bits: 0 line error, 1 rx timeout, 2 tx empty, 3 modem
   function logic [3:0] idf(input logic [3:0] en, input logic [3:0] ev);
      if (en[2] & ev[0]) return 4'h6;
      if (en[0] & ev[1]) return 4'hc;
      if (en[1] & ev[2]) return 4'h2;
      if (en[3] & ev[3]) return 4'h0;
      return 4'h1;
   endfunction
   task chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task tick;
      @(posedge mclk);
      #1;
   endtask
   // Each access opens with an edge so strobes never toggle twice in one step
   task wr(input logic [7:0] a, input logic [7:0] d);
      tick;
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1;
      tick;
      sfr_wr = 0;
   endtask
   task rdr(input logic [7:0] a);
      tick;
      sfr_addr = a;
      sfr_rd = 1;
      tick;
      sfr_rd = 0;
      rd = sfr_rdata;
   endtask
   task give_verdict;
      $display("Checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge mclk);
      #1 reset = 0;
      rdr(8'he2); chk(rd, 8'h00);
      rdr(8'he3); chk(rd, 8'hc1);
      rdr(8'he0); chk(rd, 8'h00);
      chk(rx_threshold_sel, 2'h3);
      chk(baud_prescale, 6'd27);
      $display("reset test done");
      divisor_access = 1;
      r = xs();
      wr(8'he2, r[15:8]);
      wr(8'he1, r[7:0]);
      tick; chk(baud_divisor, r[15:0]);
      rdr(8'he2); chk(rd, r[15:8]);
      divisor_access = 0;
      rdr(8'he2); chk(rd, 8'h00);
      $display("divisor test done");
      wr(8'he2, 8'h01);
      for (int s = 0; s < 4; s++) begin
         wr(8'he3, {s[1:0], 6'h01});
         rx_fill_level = thr(s) - 5'h01;
         tick; chk(rx_threshold_sel, s[1:0]);
         chk(uart_irq, 1'b0);
         rx_fill_level = thr(s);
         tick; chk(uart_irq, 1'b1);
         rdr(8'he3); chk(rd, 8'hc4);
         rx_fill_level = 5'h00;
      end
      $display("threshold test done");
      wr(8'he3, 8'hc7); chk({rx_queue_flush, tx_queue_flush}, 2'h3);
      tick; chk({rx_queue_flush, tx_queue_flush}, 2'h0);
      $display("flush test done");
      repeat (40) begin
         r = xs();
         wr(8'he2, {4'h0, r[3:0]});
         {modem_event, tx_empty_event, rx_timeout_event, line_err_event} = r[7:4];
         tick;
         {modem_event, tx_empty_event, rx_timeout_event, line_err_event} = 4'h0;
         e = idf(r[3:0], r[7:4]);
         tick; chk(uart_irq, e != 4'h1);
         rdr(8'he3); chk(rd, {4'hc, e});
         if (e == 4'h2) begin
            rdr(8'he3); chk(rd, {4'hc, idf(r[3:0], r[7:4] & 4'h8)});
         end
         rdr(8'he6); rdr(8'he7); rdr(8'he1); wr(8'he1, r[15:8]);
         rdr(8'he3); chk(rd, 8'hc1);
      end
      $display("priority test done");
      for (int k = 0; k < 2; k++) begin
         wr(8'he2, 8'h10);
         power_manage_state = 1;
         fall_req = k[0] ? 2'h2 : 2'h1;
         tick; tick;
         fall_req = 2'h0;
         n = 0;
         while (wake_irq !== 1'b1 && n < 6) begin
            tick;
            n++;
         end
         chk(wake_irq, 1'b1);
         tick; chk(wake_irq, 1'b0);
         power_manage_state = 0;
         rdr(8'he2); chk(rd, 8'h30);
         rdr(8'he2); chk(rd, 8'h10);
      end
      $display("wake test done");
      give_verdict;
   end
endmodule
